// ---- logic/sadc_ctrl.sv ----
// Successive-approximation converter control and result registers
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps

// Overview of operation
// - four-bit field selects one of sixteen inputs
// - enable bit starts continuous conversion of channel
// - end of conversion sets done, stores result
// - high-byte read or control write clears done
// - every conversion overwrites both result bytes
// - over high reference saturates to all ones
// - below low reference gives zero result
// - result code monotonic in input
// - channel change aborts, clears done, restarts
// - speed bit picks divide four or two
// - clearing enable stops any conversion
// - low byte holds two bits, rest zero
// - high byte read-only, result bits nine..two
// - done read-only, other control fields writable
// - all registers reset to zero except aux settle bit, which reads one
// - wait mode does not affect converter
// - halt disables; settle time after wake
module sadc_ctrl
    import sadc_pkg::*;
#(
    parameter int STAB_COUNT = STAB_CYCLES
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Power modes
    input  wire logic        cpu_halt,
    input  wire logic        cpu_wait,
    // Analog front end
    output logic      [3:0]  analog_input_n,
    output logic             sample_hold,
    output logic             converter_on,
    output logic      [9:0]  dac_trial,
    input  wire logic        comparator_above
);

    // Register state
    logic [7:0]  csr;
    logic [7:0]  next_csr;
    logic [9:0]  result;
    logic        done;
    // Conversion sequencer
    sadc_state_t state;
    wire logic [9:0] sar;
    logic [3:0]  bit_idx;
    logic [1:0]  step_wait;
    logic        load_trial;
    logic        step_go;
    logic        step_ok;
    logic        conv_end;
    // Converter clock enable
    logic [1:0]  div_cnt;
    logic [1:0]  div_last;
    logic        adc_tick;
    // Comparator synchroniser
    logic [2:0]  cmp_sync;
    logic        cmp_level;
    // Power modes
    logic        halt_q;
    logic [15:0] stab_cnt;
    logic        stab_ok;
    // Bus decode
    logic        req;
    logic        adr_top_zero;
    logic        sel_csr;
    logic        sel_resh;
    logic        sel_resl;
    logic        sel_aux;
    logic        csr_wr;
    logic        resh_rd;
    logic        ch_change;
    logic [3:0]  new_ch;

    // A held request is taken once; ack high blocks a second take
    assign req          = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign adr_top_zero = wb_adr_i[11:10] == 2'h0;
    assign new_ch       = wb_dat_i[CSR_CH_MSB:0];

    // Address decode on the full byte address
    always_comb
    begin
        sel_csr  = 1'b0;
        sel_resh = 1'b0;
        sel_resl = 1'b0;
        sel_aux  = 1'b0;
        if (!adr_top_zero)
        begin
            sel_csr = 1'b0;
        end
        else if (wb_adr_i[9:0] == CSR_BYTE)
        begin
            sel_csr = 1'b1;
        end
        else if (wb_adr_i[9:0] == RESH_BYTE)
        begin
            sel_resh = 1'b1;
        end
        else if (wb_adr_i[9:0] == RESL_BYTE)
        begin
            sel_resl = 1'b1;
        end
        else if (wb_adr_i[9:0] == AUX_BYTE)
        begin
            sel_aux = 1'b1;
        end
    end

    // Only byte lane 0 carries the register
    assign csr_wr    = req && wb_we_i && sel_csr && wb_sel_i[0];
    assign resh_rd   = req && !wb_we_i && sel_resh;
    // only a real channel change restarts
    assign ch_change = csr_wr && (new_ch != csr[CSR_CH_MSB:0]);

    // Bus answer one cycle after request
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req;
    end

    // Read data registered; unmapped reads return zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (req && !wb_we_i)
        begin
            wb_dat_o <= 32'h0000_0000;
            if (sel_csr)
            begin
                wb_dat_o[7:0] <= {done, csr[6:0]};
            end
            else if (sel_resh)
            begin
                wb_dat_o[7:0] <= result[9:2];
            end
            else if (sel_resl)
            begin
                wb_dat_o[7:0] <= {6'h00, result[1:0]};
            end
            else if (sel_aux)
            begin
                wb_dat_o[7:0] <= {6'h00, stab_ok, halt_q};
            end
        end
    end

    // Reserved bit 4 and the done bit are never stored
    always_comb
    begin
        next_csr                = REG_RESET;
        next_csr[CSR_SPEED_BIT] = wb_dat_i[CSR_SPEED_BIT];
        next_csr[CSR_ON_BIT]    = wb_dat_i[CSR_ON_BIT];
        next_csr[CSR_CH_MSB:0]  = new_ch;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            csr <= REG_RESET;
        end
        else if (csr_wr)
        begin
            csr <= next_csr;
        end
    end

    assign analog_input_n = csr[CSR_CH_MSB:0];
    assign converter_on   = csr[CSR_ON_BIT] && !halt_q;

    // Comparator is asynchronous: three stages, last two must agree
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cmp_sync <= 3'h0;
        else
            cmp_sync <= {cmp_sync[1:0], comparator_above};
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cmp_level <= 1'b0;
        else if (cmp_sync[2] == cmp_sync[1])
            cmp_level <= cmp_sync[2];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            halt_q <= 1'b0;
        else
            halt_q <= cpu_halt | (cpu_wait & 1'b0);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            stab_cnt <= 16'h0000;
        else if (halt_q)
            stab_cnt <= 16'(STAB_COUNT);
        else if (stab_cnt != 16'h0000)
            stab_cnt <= stab_cnt - 16'h0001;
    end
    // Status only; conversions are not held back while settling
    assign stab_ok = stab_cnt == 16'h0000;

    assign div_last = csr[CSR_SPEED_BIT] ? DIV_FAST : DIV_SLOW;
    // Restarted on a channel change so the sample phase is never cut short
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            div_cnt <= 2'h0;
        else if (!converter_on || adc_tick || ch_change)
            div_cnt <= 2'h0;
        else
            div_cnt <= div_cnt + 2'h1;
    end
    assign adc_tick = converter_on && div_cnt == div_last;

    // Sequencer strobes; a channel change outranks any step
    assign load_trial = adc_tick && !ch_change && state == SADC_SAMPLE;
    assign step_go    = adc_tick && state == SADC_STEP && step_wait == STEP_WAIT;
    assign step_ok    = step_go && !ch_change;
    assign conv_end   = step_ok && bit_idx == 4'h0;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= SADC_IDLE;
        end
        else if (!converter_on)
        begin
            state <= SADC_IDLE;
        end
        else if (ch_change)
        begin
            state <= SADC_SAMPLE;
        end
        else if (adc_tick)
        begin
            case (state)
                SADC_IDLE:
                    state <= SADC_SAMPLE;
                SADC_SAMPLE:
                    state <= SADC_STEP;
                SADC_STEP:
                begin
                    if (conv_end)
                        state <= SADC_DONE;
                end
                SADC_DONE:
                    state <= SADC_SAMPLE;
                default:
                    state <= SADC_IDLE;
            endcase
        end
    end

    // Each step waits out the comparator synchroniser latency
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            step_wait <= 2'h0;
        end
        else if (!converter_on || ch_change || state != SADC_STEP)
        begin
            step_wait <= 2'h0;
        end
        else if (step_go)
        begin
            step_wait <= 2'h0;
        end
        else if (adc_tick)
        begin
            step_wait <= step_wait + 2'h1;
        end
    end

    // Bit under trial, most significant first
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bit_idx <= 4'h0;
        end
        else if (load_trial)
        begin
            bit_idx <= 4'(RES_BITS - 1);
        end
        else if (step_ok && bit_idx != 4'h0)
        begin
            bit_idx <= bit_idx - 4'h1;
        end
    end

    for (genvar b = 0; b < RES_BITS; b++)
    begin : g_sar_bit
        logic trial_q;
        always_ff @(posedge clk or posedge rst)
        begin
            if (rst)
                trial_q <= 1'b0;
            // Trial starts at half scale
            else if (load_trial)
                trial_q <= (b == RES_BITS - 1) ? 1'b1 : 1'b0;
            // Keep the bit only while the input is at or above the trial
            else if (step_ok && bit_idx == 4'(b))
                trial_q <= cmp_level;
            else if (step_ok && bit_idx == 4'(b + 1))
                trial_q <= 1'b1;
        end
        assign sar[b] = trial_q;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            result <= 10'h000;
        else if (conv_end)
            result <= {sar[9:1], cmp_level ? sar[0] : 1'b0};
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            done <= 1'b0;
        else if (conv_end)
            done <= 1'b1;
        else if (resh_rd || csr_wr)
            done <= 1'b0;
    end

    assign sample_hold = state == SADC_SAMPLE;
    assign dac_trial   = sar;

endmodule : sadc_ctrl

// ---- logic/sadc_pkg.sv ----
// Constants and types shared by the converter control block
package sadc_pkg;
    // Register indices (printed offsets are not multiples of four)
    localparam logic [7:0] REG_CSR_IDX  = 8'h70;
    localparam logic [7:0] REG_RESH_IDX = 8'h71;
    localparam logic [7:0] REG_RESL_IDX = 8'h72;
    localparam logic [9:0] CSR_BYTE = {REG_CSR_IDX, 2'h0};
    localparam logic [9:0] RESH_BYTE = {REG_RESH_IDX, 2'h0};
    localparam logic [9:0] RESL_BYTE = {REG_RESL_IDX, 2'h0};
    localparam logic [9:0] AUX_BYTE  = 10'h1D0;
    localparam logic [9:0] SIM_BYTE  = 10'h1D4;

    // Control/status field positions
    localparam int CSR_DONE_BIT  = 7;
    localparam int CSR_SPEED_BIT = 6;
    localparam int CSR_ON_BIT    = 5;
    localparam int CSR_CH_MSB    = 3;
    localparam int AUX_HALT_BIT  = 0;
    localparam int AUX_STAB_BIT  = 1;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int RES_BITS = 10;

    // Converter clock dividers
    localparam logic [1:0] DIV_SLOW = 2'h3;
    localparam logic [1:0] DIV_FAST = 2'h1;
    // Last per-step wait count; a trial code stands three ticks before the comparator is trusted
    localparam logic [1:0] STEP_WAIT = 2'h2;

    // Settle time after halt wake-up
    localparam int CLK_MHZ = 40;
    localparam int STAB_US = 10;
    localparam int STAB_CYCLES = STAB_US * CLK_MHZ;

    typedef enum logic [1:0] {
        SADC_IDLE   = 2'b00,
        SADC_SAMPLE = 2'b01,
        SADC_STEP   = 2'b10,
        SADC_DONE   = 2'b11
    } sadc_state_t;
endpackage : sadc_pkg

// ---- verification/sadc_ctrl_assertions.sv ----
// Port assertions for the converter control block
`timescale 1ns/10ps
module sadc_chk
(
    // Clock and bus
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Converter side
    input wire logic [3:0]  analog_input_n,
    input wire logic        sample_hold,
    input wire logic        converter_on,
    input wire logic [9:0]  dac_trial
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_start;
        ##[0:8] sample_hold;
    endsequence
    a_ack_next: assert property (s_take |=> wb_ack_o) else $error("ack missing");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_rd_pad: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("pad");
    a_low_pad: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 12'h1C8)
        |-> wb_dat_o[7:2] == 6'h00) else $error("low byte pad");
    a_chan_src: assert property ($changed(analog_input_n)
        |-> wb_ack_o && analog_input_n == $past(wb_dat_i[3:0])) else $error("channel");
    a_chan_restart: assert property ($changed(analog_input_n) && converter_on
        |-> s_start) else $error("no restart");
    a_off_idle: assert property (!converter_on [*2] |-> !sample_hold) else $error("off");
    a_sample_min: assert property ($rose(sample_hold) |=> sample_hold) else $error("s");
    a_reset_zero: assert property ($past(rst) |-> !converter_on && dac_trial == 10'h000)
        else $error("reset state");
endmodule : sadc_chk

bind sadc_ctrl sadc_chk sadc_chk_i (.*);

// ---- verification/sadc_front.sv ----
// Behavioural analog inputs and comparator
`timescale 1ns/10ps
module sadc_front
(
    // Converter side
    input  wire logic [3:0] analog_input_n,
    input  wire logic [9:0] dac_trial,
    output logic            comparator_above
);
    // Levels in codes; outside 0..1023 is beyond a reference
    int lvl [16] = '{default: 0};
    assign comparator_above = lvl[analog_input_n] >= int'(dac_trial);
endmodule : sadc_front

// ---- verification/test_sadc_ctrl.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module test_sadc_ctrl;
    logic        clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic        halt = 1'h0, wt = 1'h0, ack, sh, on, above;
    logic [3:0]  ch;
    logic [7:0]  q;
    logic [9:0]  trial;
    logic [11:0] adr = 12'h000;
    logic [31:0] dat = 32'h0, dat_o;
    int          err_total = 0, checks_done = 0, ticks = 0;

    sadc_ctrl #(.STAB_COUNT(4)) sadc_ctrl_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .cpu_halt(halt), .cpu_wait(wt),
        .analog_input_n(ch), .sample_hold(sh), .converter_on(on), .dac_trial(trial),
        .comparator_above(above));
    sadc_front sadc_front_i (.analog_input_n(ch), .dac_trial(trial), .comparator_above(above));

    initial forever #12.5 clk = ~clk;
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
    end
    always @(posedge clk)
    begin
        ticks <= ticks + 1;
        if (ticks == 20000)
        begin
            err_total++;
            conclude();
        end
    end

    task automatic conclude();
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", n, exp, got);
            err_total++;
        end
    endtask : chk

    // Held until ack is sampled; hang is cut by the tick ceiling
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we  <= w;
        adr <= a;
        dat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'h1);
        q = dat_o[7:0];
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : wb

    task automatic wdone();
        int n;
        n = 0;
        do
        begin
            wb(1'h0, 12'h1C0, 8'h00);
            n++;
        end
        while (q[7] !== 1'h1 && n < 100);
        chk("done", q & 8'h80, 8'h80);
    endtask : wdone

    task automatic s_reset();
        for (int i = 0; i < 4; i++)
        begin
            wb(1'h0, 12'h1C0 + 12'(4 * i), 8'h00);
            chk("reset", q, 8'h00);
        end
    endtask : s_reset

    // Channel switch each call after the first (channel 0 is the reset value), so every later run restarts
    task automatic conv(input logic [3:0] c, input int v, input logic s);
        logic [9:0] r;
        logic [7:0] ctl;
        r = v < 0 ? 10'h000 : v > 1023 ? 10'h3FF : v[9:0];
        ctl = {1'h0, s, 1'h1, 1'h0, c};
        sadc_front_i.lvl[c] = v;
        wb(1'h1, 12'h1C0, ctl);
        wb(1'h0, 12'h1C0, 8'h00);
        chk("ctl", q, ctl);
        wdone();
        wb(1'h0, 12'h1C8, 8'h00);
        chk("low", q, {6'h00, r[1:0]});
        wb(1'h0, 12'h1C4, 8'h00);
        chk("high", q, r[9:2]);
        wb(1'h0, 12'h1C0, 8'h00);
        chk("cleared", q, ctl);
    endtask : conv

    task automatic s_csr();
        wb(1'h1, 12'h1C0, 8'hEE);
        wb(1'h0, 12'h1C0, 8'h00);
        chk("csr", q, 8'h6E);
    endtask : s_csr

    // Unread result replaced by later run
    task automatic s_over();
        sadc_front_i.lvl[14] = 700;
        wb(1'h0, 12'h1C4, 8'h00);
        wdone();
        wb(1'h0, 12'h1C4, 8'h00);
        wb(1'h0, 12'h1C0, 8'h00);
        chk("eight", q & 8'h80, 8'h00);
        wdone();
        wb(1'h0, 12'h1C8, 8'h00);
        chk("low", q, 8'h00);
        wb(1'h0, 12'h1C4, 8'h00);
        chk("high", q, 8'hAF);
    endtask : s_over

    task automatic s_off();
        wb(1'h1, 12'h1C0, 8'h0E);
        // Second write clears a done set in the same cycle as the first
        wb(1'h1, 12'h1C0, 8'h0E);
        repeat (200) @(posedge clk);
        wb(1'h0, 12'h1C0, 8'h00);
        chk("off", q, 8'h0E);
    endtask : s_off

    task automatic s_halt();
        halt <= 1'h1;
        wb(1'h1, 12'h1C0, 8'h2E);
        repeat (200) @(posedge clk);
        wb(1'h0, 12'h1C0, 8'h00);
        chk("halt", q, 8'h2E);
        wb(1'h0, 12'h1D0, 8'h00);
        chk("aux", q, 8'h01);
        halt <= 1'h0;
        wdone();
        wb(1'h0, 12'h1D0, 8'h00);
        chk("settled", q, 8'h02);
        wb(1'h0, 12'h1C4, 8'h00);
        chk("wake", q, 8'hAF);
    endtask : s_halt

    initial
    begin
        repeat (3) @(posedge clk);
        s_reset();
        wt <= 1'h1;
        for (int i = 0; i < 16; i++)
            conv(4'(i), i == 0 ? -9 : i == 15 ? 5000 : i * 61 + 3, i[0]);
        s_csr();
        s_over();
        s_off();
        s_halt();
        conclude();
    end
endmodule : test_sadc_ctrl
